// ==== hdl/rep_ctrl_pkg.sv ====
/*
 * constants shared by the repeater enable controller and its bus watcher.
 * assumes a single core clock of 125 MHz and bus lines already synchronous
 * to it.
 */
package rep_ctrl_pkg;
   // ------------------------------------------------------------------
   // clock
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8; // 125 MHz core clock

   // ------------------------------------------------------------------
   // bus free time before a segment counts as idle
   // ------------------------------------------------------------------
   localparam int unsigned BUS_FREE_NS = 1300; // fast-mode free time
   // least time, so round up to whole cycles
   localparam int unsigned BUS_FREE_CYCLES =
      (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FREE_CNT_W = 8; // holds BUS_FREE_CYCLES
   localparam logic [7:0] FREE_CNT_RST = 8'h00; // free counter at reset

   // ------------------------------------------------------------------
   // power-up isolation of the repeater
   // ------------------------------------------------------------------
   localparam int unsigned POWERUP_HOLD_US = 1000; // enable held low
   localparam int unsigned POWERUP_HOLD_CYCLES_DEF =
      (POWERUP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] HOLD_CNT_RST = 32'h0000_0000;

   // ------------------------------------------------------------------
   // controller states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00, // power-up: repeater kept isolated
      ST_OFF  = 2'b01, // repeater disabled
      ST_ON   = 2'b10  // repeater enabled
   } ctrl_state_e;
endpackage : rep_ctrl_pkg

// ==== hdl/seg_idle_watch.sv ====
/*
 * watches one bus segment (clock and data line levels) and reports when
 * it is idle: no transfer open since the last stop and both lines high
 * for at least the bus free time.
 * assumes the line levels are synchronous to i_clk.
 */
module seg_idle_watch
   import rep_ctrl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_idle
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic scl_q, scl_d; // previous clock line level
   logic sda_q, sda_d; // previous data line level
   logic busy_q, busy_d; // a transfer is open
   logic [FREE_CNT_W-1:0] free_q, free_d; // cycles with both lines high
   logic idle_q, idle_d;
   logic start_c, stop_c;

   localparam logic [FREE_CNT_W-1:0] FREE_MAX =
      FREE_CNT_W'(BUS_FREE_CYCLES);

   // start and stop are data edges while the clock line stays high
   assign start_c = scl_q & i_scl & sda_q & ~i_sda;
   assign stop_c = scl_q & i_scl & ~sda_q & i_sda;

   // next values
   always_comb begin
      scl_d = i_scl;
      sda_d = i_sda;
      busy_d = busy_q;
      if (start_c) begin
         busy_d = 1'b1; // transfer opened
      end else if (stop_c) begin
         busy_d = 1'b0; // transfer closed
      end
      // any low on either line restarts the free-time count; counting in
      // core cycles keeps the watch valid for any line rate, from a
      // stalled clock up to fast mode
      if (!(i_scl && i_sda)) begin
         free_d = FREE_CNT_RST;
      end else if (free_q != FREE_MAX) begin
         free_d = free_q + 1'b1;
      end else begin
         free_d = free_q; // saturate
      end
      idle_d = ~busy_d & (free_d == FREE_MAX);
   end

   // registers; lines are assumed released (high) at reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         busy_q <= 1'b0;
         free_q <= FREE_CNT_RST;
         idle_q <= 1'b0;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
         busy_q <= busy_d;
         free_q <= free_d;
         idle_q <= idle_d;
      end
   end

   assign o_idle = idle_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_start_not_idle: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      start_c |=> !o_idle)
      else $error("segment shown idle right after a start");
   a_low_clears_idle: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      (!i_scl || !i_sda) |=> !o_idle)
      else $error("segment shown idle while a line was low");
endmodule : seg_idle_watch

// ==== hdl/repeater_enable_ctrl.sv ====
/*
 * controller for the enable pin of a two-segment bus repeater. it keeps
 * the repeater isolated after reset for a hold time, then follows a user
 * request, changing the enable level only while both segments are idle.
 * assumes the four bus line levels are sampled synchronously to
 * i_core_clk and that the enable pin is driven push-pull by this block.
 */
// Overview of operation
// - change enable only when both segments idle
// - hold enable low until power-up reset done
// - never place two repeaters in series
// - masters clock from static up to 400 kHz
module repeater_enable_ctrl
   import rep_ctrl_pkg::*;
#(
   parameter int unsigned POWERUP_HOLD_CYCLES =
      rep_ctrl_pkg::POWERUP_HOLD_CYCLES_DEF
)(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_enable_req,        // user wants the repeater on
   input wire logic i_clock_line_side_a, // level seen on side a clock
   input wire logic i_data_line_side_a,  // level seen on side a data
   input wire logic i_clock_line_side_b, // level seen on side b clock
   input wire logic i_data_line_side_b,  // level seen on side b data
   output logic o_rep_en,    // to the repeater enable pin
   output logic o_bus_idle,  // both segments idle
   output logic o_hold_done  // power-up isolation finished
);
   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   logic rst_meta_q, rst_sync_q;
   logic rst_n;

   // reset asserts at once but releases through two flops; a release
   // that lands near a clock edge could otherwise leave some flops reset
   // and others running for one cycle
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // ------------------------------------------------------------------
   // segment watchers
   // ------------------------------------------------------------------
   logic idle_a, idle_b; // registered idle per segment
   logic idle_both;
   logic lines_high; // all four lines released right now

   // the main bus and the repeater port are watched the same way; only
   // one repeater stage is steered, since a second stage in series would
   // not pass the first stage's low on
   seg_idle_watch u_watch_a (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_scl(i_clock_line_side_a),
      .i_sda(i_data_line_side_a),
      .o_idle(idle_a)
   );
   // side b is the repeater port
   seg_idle_watch u_watch_b (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_scl(i_clock_line_side_b),
      .i_sda(i_data_line_side_b),
      .o_idle(idle_b)
   );
   // the watchers' idle is one cycle old; a start landing on the very
   // edge of a request change would slip past it, so the present line
   // levels gate the decision as well
   assign lines_high = i_clock_line_side_a & i_data_line_side_a &
      i_clock_line_side_b & i_data_line_side_b;
   assign idle_both = idle_a & idle_b & lines_high;

   // ------------------------------------------------------------------
   // enable sequencing
   // ------------------------------------------------------------------
   // hold end is the last count value; the done flag follows one edge
   // later, together with the move to the off state
   localparam logic [31:0] HOLD_END = 32'(POWERUP_HOLD_CYCLES);

   ctrl_state_e state_q, state_d;
   logic [31:0] hold_q, hold_d; // power-up hold counter
   logic en_q, en_d;            // enable pin level
   logic idle_q, idle_d;        // copy of idle_both for the port
   logic done_q, done_d;        // hold time has run out

   // next values; a request that arrives mid-transfer simply waits,
   // which trades enable latency for never cutting a transfer in two
   always_comb begin
      state_d = state_q;
      hold_d = hold_q;
      en_d = en_q;
      done_d = done_q;
      idle_d = idle_both;
      case (state_q)
         ST_HOLD: begin
            en_d = 1'b0; // keep a misbehaving slave off the bus
            if (hold_q == HOLD_END) begin
               state_d = ST_OFF;
               done_d = 1'b1;
            end else begin
               hold_d = hold_q + 32'h0000_0001;
            end
         end
         ST_OFF: begin
            // only switch on between transfers
            if (i_enable_req && idle_both) begin
               state_d = ST_ON;
               en_d = 1'b1; // repeater becomes active
            end
         end
         ST_ON: begin
            // disabling mid-transfer would hang the bus
            if (!i_enable_req && idle_both) begin
               state_d = ST_OFF;
               en_d = 1'b0; // repeater isolates both segments
            end
         end
         default: begin
            state_d = ST_HOLD;
            en_d = 1'b0;
         end
      endcase
   end

   // registers only; the enable pin is push-pull from here, so the
   // pin's own pull-up only matters while this block is unpowered,
   // a limitation the board must live with
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_HOLD;
         hold_q <= HOLD_CNT_RST;
         en_q <= 1'b0; // pin low from reset on
         idle_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         hold_q <= hold_d;
         en_q <= en_d;
         idle_q <= idle_d;
         done_q <= done_d;
      end
   end

   // every output is a register copy, so no glitch reaches the pin
   // or the status lines
   assign o_rep_en = en_q;
   assign o_bus_idle = idle_q;
   assign o_hold_done = done_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   // an enable edge is always preceded by a cycle with both segments idle
   sequence s_idle_seen;
      idle_both;
   endsequence
   sequence s_en_moves;
      ##1 (en_q != $past(en_q));
   endsequence
   // a request that meets an idle bus while the repeater is off
   sequence s_on_asked;
      (state_q == ST_OFF && i_enable_req) ##0 s_idle_seen;
   endsequence
   // a dropped request that meets an idle bus while the repeater is on
   sequence s_off_asked;
      (state_q == ST_ON && !i_enable_req) ##0 s_idle_seen;
   endsequence

   // all checks sleep while the internal reset is low
   a_en_idle_only: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      s_en_moves |-> $past(idle_both))
      else $error("enable changed while a segment was busy");
   a_hold_keeps_low: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      !o_hold_done |-> !o_rep_en)
      else $error("enable high before power-up hold ended");
   a_hold_length: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      (state_q == ST_HOLD && hold_q == HOLD_END) |=> o_hold_done)
      else $error("hold did not end at its count");
   a_hold_not_early: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      (state_q == ST_HOLD && hold_q != HOLD_END) |=> !o_hold_done)
      else $error("hold ended before its count");
   a_done_sticky: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      o_hold_done |=> o_hold_done)
      else $error("hold flag fell without a reset");
   a_turn_on: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      s_on_asked |=> o_rep_en)
      else $error("idle request did not enable the repeater");
   a_turn_off: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      s_off_asked |=> !o_rep_en)
      else $error("idle drop of request did not disable");
   a_busy_holds_en: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      (o_hold_done && !idle_both) |=> $stable(o_rep_en))
      else $error("enable moved during a busy cycle");
   a_low_line_holds: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      !lines_high |=> $stable(o_rep_en))
      else $error("enable moved while a line was low");
   a_off_stays_off: assert property (@(posedge i_core_clk)
      disable iff (!rst_n)
      (state_q == ST_OFF && !i_enable_req) |=> !o_rep_en)
      else $error("repeater enabled without a request");
endmodule : repeater_enable_ctrl

// ==== tb/rep_device_model.sv ====
/* behavioural model of the two-segment bus repeater device.
   assumes open-drain lines with pull-ups, given here as levels. */
module rep_device_model (
   input wire logic i_en,       // enable pin, floating reads high
   input wire logic i_pd_clk_a, // external pull-down, side a clock
   input wire logic i_pd_dat_a, // external pull-down, side a data
   input wire logic i_pd_clk_b, // external pull-down, side b clock
   input wire logic i_pd_dat_b, // external pull-down, side b data
   output logic o_clk_a,        // resolved side a clock level
   output logic o_dat_a,        // resolved side a data level
   output logic o_clk_b,        // resolved side b clock level
   output logic o_dat_b         // resolved side b data level
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------
   // channels
   // --------
   logic en; // internal pull-up: only a firm low disables
   assign en = (i_en !== 1'b0);
   // a side is pulled only by the far side's external low, never by
   // its own drive, so the pair cannot lock up
   assign o_clk_a = ~(i_pd_clk_a | (en & i_pd_clk_b));
   assign o_dat_a = ~(i_pd_dat_a | (en & i_pd_dat_b));
   assign o_clk_b = ~(i_pd_clk_b | (en & i_pd_clk_a));
   assign o_dat_b = ~(i_pd_dat_b | (en & i_pd_dat_a));
endmodule : rep_device_model

// ==== tb/repeater_enable_ctrl_tb.sv ====
/* self-checking bench for the repeater enable controller.
   assumes the device model rep_device_model closes the loop. */
module repeater_enable_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rep_ctrl_pkg::*;
   // --------
   // signals
   // --------
   localparam int HOLD = 20; // short power-up hold keeps the run brief
   localparam int WAIT = BUS_FREE_CYCLES + 20; // idle wait bound
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_enable_req = 1'b1; // asked for early, must be refused
   logic pd_ca = 1'b0, pd_da = 1'b0, pd_cb = 1'b0, pd_db = 1'b0;
   logic lca, lda, lcb, ldb; // resolved line levels
   logic o_rep_en, o_bus_idle, o_hold_done;
   int n_errors = 0;
   int checked = 0;
   // clock: 8 ns period
   always #4 i_core_clk = ~i_core_clk;
   repeater_enable_ctrl #(.POWERUP_HOLD_CYCLES(HOLD)) u_dut (
      .i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_enable_req(i_enable_req),
      .i_clock_line_side_a(lca), .i_data_line_side_a(lda),
      .i_clock_line_side_b(lcb), .i_data_line_side_b(ldb),
      .o_rep_en(o_rep_en), .o_bus_idle(o_bus_idle),
      .o_hold_done(o_hold_done));
   rep_device_model u_dev (
      .i_en(o_rep_en), .i_pd_clk_a(pd_ca), .i_pd_dat_a(pd_da),
      .i_pd_clk_b(pd_cb), .i_pd_dat_b(pd_db), .o_clk_a(lca),
      .o_dat_a(lda), .o_clk_b(lcb), .o_dat_b(ldb));
   // --------
   // helpers
   // --------
   task tally_and_finish;
      if (n_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task check(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t: got %b want %b", $time, seen, exp);
      end
   endtask : check
   task ticks(input int k);
      repeat (k) @(negedge i_core_clk);
   endtask : ticks
   // bounded wait for the enable pin; running out ends the run
   task wait_en(input logic v);
      int i;
      for (i = 0; i < WAIT && o_rep_en !== v; i++) ticks(1);
      if (o_rep_en !== v) begin
         n_errors++;
         $display("BAD %0t: enable wait ran out", $time);
         tally_and_finish();
      end
   endtask : wait_en
   // --------
   // scenarios
   // --------
   // isolated through the hold even though enable is requested
   task t_powerup;
      int n;
      n = 0;
      while (o_hold_done !== 1'b1 && n < HOLD + 10) begin
         check(o_rep_en, 1'b0);
         ticks(1);
         n++;
      end
      check(o_hold_done, 1'b1);
      check(n > HOLD, 1'b1);
   endtask : t_powerup
   // enable waits for the free time, then lows cross both ways
   task t_enable;
      check(o_rep_en, 1'b0);
      wait_en(1'b1);
      check(o_bus_idle, 1'b1);
      pd_da = 1'b1;
      ticks(1);
      check(ldb, 1'b0);
      pd_da = 1'b0;
      pd_cb = 1'b1;
      ticks(1);
      check(lda, 1'b1);
      check(lca, 1'b0);
      pd_da = 1'b1; // data low under a low clock
      ticks(1);
      pd_cb = 1'b0; // clock back up, data still low
      ticks(1);
      check(ldb, 1'b0);
      pd_da = 1'b0; // data rises under a high clock: stop
      ticks(1);
   endtask : t_enable
   // disable asked mid-transfer on side b is held off until idle
   task t_defer_off;
      ticks(WAIT);
      pd_db = 1'b1;
      i_enable_req = 1'b0;
      ticks(30);
      check(o_rep_en, 1'b1);
      pd_db = 1'b0;
      wait_en(1'b0);
      check(o_bus_idle, 1'b1);
   endtask : t_defer_off
   // disabled: a side a low does not reach side b; enable waits for side a to stop
   task t_isolate;
      pd_da = 1'b1;
      i_enable_req = 1'b1;
      ticks(30);
      check(ldb, 1'b1);
      check(o_rep_en, 1'b0);
      pd_da = 1'b0;
      wait_en(1'b1);
      check(o_bus_idle, 1'b1);
   endtask : t_isolate
   // a second reset isolates the repeater again at once
   task t_rereset;
      i_resetn = 1'b0;
      ticks(1);
      check(o_rep_en, 1'b0);
      check(o_hold_done, 1'b0);
      i_resetn = 1'b1;
      t_powerup(); // hold runs again after the second release
   endtask : t_rereset
   // main sequence: reset for 10 cycles, then each scenario
   initial begin
      ticks(10);
      i_resetn = 1'b1;
      t_powerup();
      t_enable();
      t_defer_off();
      t_isolate();
      t_rereset();
      tally_and_finish();
   end
endmodule : repeater_enable_ctrl_tb
